// >>> hdl/compat_timer1_counter_regs.sv
// Eight-bit timer with compare channels, PWM and its register block
//
// What this block does
// R1: Clear-on-compare set: counter goes to zero the cycle after compare-A match.
// R2: Clear-on-compare clear: compare match leaves the count alone.
// R3: PWM-A enable selects PWM; counter returns to zero after compare-C match.
// R4: Outside PWM, output mode 00 off, 01 toggle, 10 clear, 11 set on match.
// R5: Software must set the pin direction bit before the output drives the pin.
// R6: Clock select: 0 stops, 1-4 peripheral clock /1../8, 5-15 CPU /1../1024.
// R7: Force-compare-A applies the output action like a match, no flag set.
// R8: Force-compare-A reads zero and does nothing in PWM mode.
// R9: Prescaler reset bit clears the prescaler only, self-clears, reads zero.
// R10: Counter is read/write; a write lands one cycle later.
// R11: Compare-A matches only when counting into the value, not on writes.
// R12: Compare-A match sets its flag after a synchronising delay.
// R13: Compare-C matches only by counting; with clear-on-compare it clears counter.
// R14: Compare-A flag, its enable and global enable request interrupt vector 3.
// R15: Overflow flag, its enable and global enable request interrupt vector 4.
// R16: Compare-A flag clears on vector execution or one cycle after writing one.
// R17: Overflow flag sets on overflow, clears on vector or write of one.
// R18: Reserved mask/flag bits 7 and 0 and PLL bits 6 to 3 read zero.
// R19: In legacy mode the peripheral clock enable bit reads one.
// R20: Overflow on wrap from FF; in PWM also on reset from compare-C.
// R21: PWM mode 10 clears on match, sets at zero; 11 reverse; 00/01 off.
// R22: In PWM, compare-A writes are buffered until the counter reaches compare-C.
// R23: A flag set coinciding with a software clear leaves the flag set.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module compat_timer1_counter_regs (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWriteData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regReadData,
    input  wire logic       fastPeriphClock,
    input  wire logic       globalIrqEnable,
    input  wire logic       legacyMode,
    input  wire logic       portDirection,
    input  wire logic       compareAVectorAck,
    input  wire logic       overflowVectorAck,
    output logic            compareAIrq,
    output logic            overflowIrq,
    output logic            compareAOutput,
    output logic            compareAOutputEnable
);
    import timer1_pkg::*;

    logic [7:0] timerControl;
    logic [7:0] counterValue;
    logic [7:0] compareAActive;
    logic [7:0] compareABuffer;
    logic [7:0] compareCValue;
    logic       compareAIrqEnable;
    logic       overflowIrqEnable;
    logic       compareAFlag;
    logic       overflowFlag;
    logic       periphClockEnable;
    logic       counterWritePending;
    logic [7:0] counterWriteData;
    logic       clearAPending;
    logic       clearOvfPending;
    logic       matchAHit;
    logic       matchCHit;
    logic       wrapHit;
    logic       periphSync;
    logic       periphPrev;
    logic       periphEdge;
    logic       tick;
    logic       advance;
    logic       clearNow;
    logic       prescalerClear;
    logic       forceA;
    logic [7:0] nextCount;
    logic [7:0] next_readData;

    logic       clearOnCompare;
    logic       pwmAEnable;
    out_mode_t  outModeA;
    logic [3:0] clockSelect;

    assign clearOnCompare = timerControl[BIT_CLEAR_ON_COMPARE];
    assign pwmAEnable     = timerControl[BIT_PWM_A_ENABLE];
    assign outModeA       = out_mode_t'(timerControl[BIT_OUT_MODE_A_HI:BIT_OUT_MODE_A_LO]);
    assign clockSelect    = timerControl[3:0];

    logic wrGeneral;
    logic wrCounter;
    logic wrControl;
    logic wrFlags;
    logic wrMask;
    logic wrCompareA;
    logic wrCompareC;
    logic wrPll;

    // Address decode for writes
    always_comb begin
        wrGeneral  = 1'b0;
        wrCounter  = 1'b0;
        wrControl  = 1'b0;
        wrFlags    = 1'b0;
        wrMask     = 1'b0;
        wrCompareA = 1'b0;
        wrCompareC = 1'b0;
        wrPll      = 1'b0;
        if (!regWrite) begin
            wrGeneral = 1'b0;
        end else if (regAddr == ADDR_GENERAL_CTRL) begin
            wrGeneral = 1'b1;
        end else if (regAddr == ADDR_COUNTER) begin
            wrCounter = 1'b1;
        end else if (regAddr == ADDR_TIMER_CTRL) begin
            wrControl = 1'b1;
        end else if (regAddr == ADDR_IRQ_FLAGS) begin
            wrFlags = 1'b1;
        end else if (regAddr == ADDR_IRQ_MASK) begin
            wrMask = 1'b1;
        end else if (regAddr == ADDR_COMPARE_A) begin
            wrCompareA = 1'b1;
        end else if (regAddr == ADDR_COMPARE_C) begin
            wrCompareC = 1'b1;
        end else if (regAddr == ADDR_PLL_CTRL) begin
            wrPll = 1'b1;
        end
    end

    // Peripheral clock arrives from another domain
    pin_sync #(
        .WIDTH (1)
    ) periph_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .asyncIn (fastPeriphClock),
        .syncOut (periphSync)
    );

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            periphPrev <= 1'b0;
        end else begin
            periphPrev <= periphSync;
        end
    end

    assign periphEdge     = periphSync && !periphPrev;
    assign prescalerClear = wrGeneral && regWriteData[BIT_PRESCALER_RESET];  // see R9
    assign forceA         = wrGeneral && regWriteData[BIT_FORCE_COMPARE_A] && !pwmAEnable;  // see R8

    timer1_prescaler #(
        .CPU_DIV_BITS (10)
    ) prescaler (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .clear       (prescalerClear),
        .periphEdge  (periphEdge),
        .clockSelect (clockSelect),
        .tick        (tick)
    );  // see R6

    // Clearing is one cycle after the match; PWM always clears on compare-C
    assign clearNow  = (matchAHit && clearOnCompare && !pwmAEnable)
                     || (matchCHit && (clearOnCompare || pwmAEnable));  // see R1, R2, R3, R13
    assign advance   = tick && !counterWritePending && !clearNow;
    assign nextCount = counterValue + 8'h01;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timerControl <= RESET_TIMER_CTRL;
        end else if (wrControl) begin
            timerControl <= regWriteData;
        end
    end

    // Written count lands a cycle later so match logic never sees it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            counterWritePending <= 1'b0;
            counterWriteData    <= RESET_COUNTER;
        end else begin
            counterWritePending <= wrCounter;  // see R10
            if (wrCounter) begin
                counterWriteData <= regWriteData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            counterValue <= RESET_COUNTER;
        end else if (counterWritePending) begin
            counterValue <= counterWriteData;  // see R10
        end else if (clearNow) begin
            counterValue <= COUNT_ZERO;
        end else if (advance) begin
            counterValue <= nextCount;
        end
    end

    // Matches only from counting, never from a write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            matchAHit <= 1'b0;
            matchCHit <= 1'b0;
            wrapHit   <= 1'b0;
        end else begin
            matchAHit <= advance && (nextCount == compareAActive);  // see R11
            matchCHit <= advance && (nextCount == compareCValue);  // see R13
            wrapHit   <= advance && (counterValue == COUNT_TOP);  // see R20
        end
    end

    // Buffered compare value in PWM avoids glitching pulses
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            compareABuffer <= RESET_COMPARE_A;
            compareAActive <= RESET_COMPARE_A;
        end else begin
            if (wrCompareA) begin
                compareABuffer <= regWriteData;
            end
            if (wrCompareA && !pwmAEnable) begin
                compareAActive <= regWriteData;
            end else if (pwmAEnable && matchCHit) begin
                compareAActive <= compareABuffer;  // see R22
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            compareCValue <= RESET_COMPARE_C;
        end else if (wrCompareC) begin
            compareCValue <= regWriteData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            compareAIrqEnable <= 1'b0;
            overflowIrqEnable <= 1'b0;
        end else if (wrMask) begin
            compareAIrqEnable <= regWriteData[BIT_COMPARE_A];
            overflowIrqEnable <= regWriteData[BIT_OVERFLOW];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            periphClockEnable <= 1'b0;
        end else if (wrPll) begin
            periphClockEnable <= regWriteData[BIT_PERIPH_CLK_EN];
        end
    end

    // Write-one clears take one synchronising cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clearAPending   <= 1'b0;
            clearOvfPending <= 1'b0;
        end else begin
            clearAPending   <= wrFlags && regWriteData[BIT_COMPARE_A];
            clearOvfPending <= wrFlags && regWriteData[BIT_OVERFLOW];
        end
    end

    // Set wins over any clear so no event is lost
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            compareAFlag <= 1'b0;
        end else if (matchAHit) begin
            compareAFlag <= 1'b1;  // see R12, R23
        end else if (clearAPending || compareAVectorAck) begin
            compareAFlag <= 1'b0;  // see R16
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            overflowFlag <= 1'b0;
        end else if (wrapHit || (pwmAEnable && matchCHit)) begin
            overflowFlag <= 1'b1;  // see R17, R20, R23
        end else if (clearOvfPending || overflowVectorAck) begin
            overflowFlag <= 1'b0;  // see R17
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            compareAIrq <= 1'b0;
            overflowIrq <= 1'b0;
        end else begin
            compareAIrq <= compareAFlag && compareAIrqEnable && globalIrqEnable;  // see R14
            overflowIrq <= overflowFlag && overflowIrqEnable && globalIrqEnable;  // see R15
        end
    end

    // Compare output pin
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            compareAOutput <= 1'b0;
        end else if (pwmAEnable) begin
            if (outModeA == OUT_CLEAR) begin
                if (matchAHit) begin
                    compareAOutput <= 1'b0;  // see R21
                end else if (wrapHit || clearNow) begin
                    compareAOutput <= 1'b1;
                end
            end else if (outModeA == OUT_SET) begin
                if (matchAHit) begin
                    compareAOutput <= 1'b1;  // see R21
                end else if (wrapHit || clearNow) begin
                    compareAOutput <= 1'b0;
                end
            end
        end else if (matchAHit || forceA) begin
            case (outModeA)  // see R4, R7
                OUT_TOGGLE: begin
                    compareAOutput <= !compareAOutput;
                end
                OUT_CLEAR: begin
                    compareAOutput <= 1'b0;
                end
                OUT_SET: begin
                    compareAOutput <= 1'b1;
                end
                default: begin
                    compareAOutput <= compareAOutput;
                end
            endcase
        end
    end

    // Pin is driven only with the direction bit set by software
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            compareAOutputEnable <= 1'b0;
        end else begin
            compareAOutputEnable <= portDirection
                && (pwmAEnable ? outModeA[1] : (outModeA != OUT_OFF));  // see R5, R21
        end
    end

    // Read mux; strobe bits and reserved bits read zero
    always_comb begin
        next_readData = 8'h00;
        if (!regRead) begin
            next_readData = 8'h00;
        end else if (regAddr == ADDR_GENERAL_CTRL) begin
            next_readData = 8'h00;  // see R8, R9
        end else if (regAddr == ADDR_COUNTER) begin
            next_readData = counterValue;
        end else if (regAddr == ADDR_TIMER_CTRL) begin
            next_readData = timerControl;
        end else if (regAddr == ADDR_IRQ_FLAGS) begin
            next_readData[BIT_COMPARE_A] = compareAFlag;  // see R18
            next_readData[BIT_OVERFLOW]  = overflowFlag;
        end else if (regAddr == ADDR_IRQ_MASK) begin
            next_readData[BIT_COMPARE_A] = compareAIrqEnable;  // see R18
            next_readData[BIT_OVERFLOW]  = overflowIrqEnable;
        end else if (regAddr == ADDR_COMPARE_A) begin
            next_readData = compareABuffer;  // see R22
        end else if (regAddr == ADDR_COMPARE_C) begin
            next_readData = compareCValue;
        end else if (regAddr == ADDR_PLL_CTRL) begin
            next_readData[BIT_PERIPH_CLK_EN] = periphClockEnable || legacyMode;  // see R18, R19
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            regReadData <= 8'h00;
        end else begin
            regReadData <= next_readData;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/timer1_pkg.sv
// Register map, field positions and reset values of the eight-bit timer
`default_nettype none
package timer1_pkg;
    localparam logic [7:0] ADDR_GENERAL_CTRL   = 8'h2C;
    localparam logic [7:0] ADDR_COUNTER        = 8'h2F;
    localparam logic [7:0] ADDR_TIMER_CTRL     = 8'h30;
    localparam logic [7:0] ADDR_IRQ_FLAGS      = 8'h38;
    localparam logic [7:0] ADDR_IRQ_MASK       = 8'h39;
    localparam logic [7:0] ADDR_COMPARE_A      = 8'h31;
    localparam logic [7:0] ADDR_COMPARE_C      = 8'h32;
    localparam logic [7:0] ADDR_PLL_CTRL       = 8'h33;

    localparam int BIT_CLEAR_ON_COMPARE = 7;
    localparam int BIT_PWM_A_ENABLE     = 6;
    localparam int BIT_OUT_MODE_A_HI    = 5;
    localparam int BIT_OUT_MODE_A_LO    = 4;
    localparam int BIT_FORCE_COMPARE_A  = 2;
    localparam int BIT_PRESCALER_RESET  = 1;
    localparam int BIT_COMPARE_A        = 6;
    localparam int BIT_OVERFLOW         = 2;
    localparam int BIT_PERIPH_CLK_EN    = 2;

    localparam logic [7:0] RESET_TIMER_CTRL = 8'h00;
    localparam logic [7:0] RESET_COUNTER    = 8'h00;
    localparam logic [7:0] RESET_COMPARE_A  = 8'h00;
    localparam logic [7:0] RESET_COMPARE_C  = 8'hFF;
    localparam logic [7:0] COUNT_TOP        = 8'hFF;
    localparam logic [7:0] COUNT_ZERO       = 8'h00;

    localparam logic [3:0] CS_STOP        = 4'h0;
    localparam logic [3:0] CS_PERIPH_LAST = 4'h4;
    localparam logic [3:0] CS_CPU_FIRST   = 4'h5;

    typedef enum logic [1:0] {
        OUT_OFF    = 2'b00,
        OUT_TOGGLE = 2'b01,
        OUT_CLEAR  = 2'b10,
        OUT_SET    = 2'b11
    } out_mode_t;
endpackage
`default_nettype wire

// >>> hdl/pin_sync.sv
// Two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] firstStage;

    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            firstStage <= '0;
            syncOut    <= '0;
        end else begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/timer1_prescaler.sv
// Counter clock prescaler: fast peripheral clock or CPU clock source
`timescale 1ns/1ps
`default_nettype none
module timer1_prescaler
    import timer1_pkg::*;
#(
    parameter int CPU_DIV_BITS = 10
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       clear,
    input  wire logic       periphEdge,
    input  wire logic [3:0] clockSelect,
    output logic            tick
);
    logic [2:0]              periphDiv;
    logic [CPU_DIV_BITS-1:0] cpuDiv;
    logic [3:0]              shift;

    always_ff @(posedge sys_clk) begin
        if (reset || clear) begin
            periphDiv <= 3'h0;
            cpuDiv    <= '0;
        end else begin
            cpuDiv <= cpuDiv + 1'b1;
            if (periphEdge) begin
                periphDiv <= periphDiv + 3'h1;
            end
        end
    end

    // Tick when the low bits of the divider are all ones
    always_comb begin
        shift = 4'h0;
        tick  = 1'b0;
        if (clockSelect == CS_STOP) begin
            tick = 1'b0;
        end else if (clockSelect <= CS_PERIPH_LAST) begin
            shift = clockSelect - 4'h1;
            tick  = periphEdge && ((periphDiv | ~(3'h7 >> (4'h3 - shift))) == 3'h7);
        end else begin
            shift = clockSelect - CS_CPU_FIRST;
            tick  = &(cpuDiv | ~(CPU_DIV_BITS'((1 << shift) - 1)));
        end
    end
endmodule
`default_nettype wire

// >>> verification/timer1_monitor.sv
// Port-level assertions for the eight-bit timer register block
`timescale 1ns/1ps
`default_nettype none
module timer1_monitor
    import timer1_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWriteData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regReadData,
    input  wire logic       fastPeriphClock,
    input  wire logic       globalIrqEnable,
    input  wire logic       legacyMode,
    input  wire logic       portDirection,
    input  wire logic       compareAVectorAck,
    input  wire logic       overflowVectorAck,
    input  wire logic       compareAIrq,
    input  wire logic       overflowIrq,
    input  wire logic       compareAOutput,
    input  wire logic       compareAOutputEnable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Read data is only meaningful one cycle after the strobe
    sequence read_of(logic [7:0] a);
        regRead && regAddr == a;
    endsequence

    a_idle_read_zero: assert property (!regRead |=> regReadData == 8'h00)
        else $error("read data not zero without a read");
    a_mask_reserved_zero: assert property (read_of(ADDR_IRQ_MASK) |=> !regReadData[7] && !regReadData[0])
        else $error("mask reserved bits not zero");
    a_flag_reserved_zero: assert property (read_of(ADDR_IRQ_FLAGS) |=> !regReadData[7] && !regReadData[0])
        else $error("flag reserved bits not zero");
    a_pll_reserved_zero: assert property (read_of(ADDR_PLL_CTRL) |=> regReadData[6:3] == 4'h0)
        else $error("pll reserved bits not zero");
    a_pll_legacy_one: assert property (read_of(ADDR_PLL_CTRL) ##0 legacyMode |=> regReadData[2])
        else $error("clock enable not one in legacy mode");
    a_general_reads_zero: assert property (read_of(ADDR_GENERAL_CTRL) |=> regReadData == 8'h00)
        else $error("general control not zero");
    a_compare_irq_global: assert property (compareAIrq |-> $past(globalIrqEnable))
        else $error("compare irq without global enable");
    a_overflow_irq_global: assert property (overflowIrq |-> $past(globalIrqEnable))
        else $error("overflow irq without global enable");
    a_drive_needs_dir: assert property (compareAOutputEnable |-> $past(portDirection))
        else $error("pin driven without direction bit");
    a_reset_quiet_out: assert property ($fell(reset) |-> !compareAIrq && !overflowIrq && !compareAOutputEnable)
        else $error("outputs active after reset");
endmodule

bind compat_timer1_counter_regs timer1_monitor timer1_monitor_inst (
    .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .fastPeriphClock(fastPeriphClock),
    .globalIrqEnable(globalIrqEnable), .legacyMode(legacyMode), .portDirection(portDirection),
    .compareAVectorAck(compareAVectorAck), .overflowVectorAck(overflowVectorAck),
    .compareAIrq(compareAIrq), .overflowIrq(overflowIrq), .compareAOutput(compareAOutput),
    .compareAOutputEnable(compareAOutputEnable)
);
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the eight-bit timer register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import timer1_pkg::*;
    logic       sysClk;
    logic       reset;
    logic [7:0] regAddr;
    logic [7:0] regWriteData;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regReadData;
    logic       fastPeriphClock;
    logic       globalIrqEnable;
    logic       legacyMode;
    logic       portDirection;
    logic       compareAVectorAck;
    logic       overflowVectorAck;
    logic       compareAIrq;
    logic       overflowIrq;
    logic       compareAOutput;
    logic       compareAOutputEnable;
    logic [7:0] seen;
    int         errors;
    int         totalChecks;
    logic [7:0] resetAddr [9] = '{8'h2C, 8'h2F, 8'h30, 8'h38, 8'h39, 8'h31, 8'h32, 8'h33, 8'h40};
    logic [7:0] resetVal  [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h04, 8'h00};
    logic [1:0] modeSeq   [5] = '{2'b11, 2'b10, 2'b01, 2'b01, 2'b00};
    logic [1:0] pinSeq    [5] = '{2'b11, 2'b10, 2'b11, 2'b10, 2'b00};

    compat_timer1_counter_regs compat_timer1_counter_regs_inst (
        .sys_clk(sysClk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .fastPeriphClock(fastPeriphClock),
        .globalIrqEnable(globalIrqEnable), .legacyMode(legacyMode), .portDirection(portDirection),
        .compareAVectorAck(compareAVectorAck), .overflowVectorAck(overflowVectorAck),
        .compareAIrq(compareAIrq), .overflowIrq(overflowIrq), .compareAOutput(compareAOutput),
        .compareAOutputEnable(compareAOutputEnable)
    );

    always #12.5 sysClk = ~sysClk;
    // Unrelated rate, synchronised inside the block
    always #19.5 fastPeriphClock = ~fastPeriphClock;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sysClk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge sysClk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sysClk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sysClk);
        regRead <= 1'b0;
        #1 d = regReadData;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sysClk);
    endtask

    // Counts from a start value with the chosen source for a fixed span, then stops
    task automatic run(input logic [7:0] start, input logic [7:0] ctrl, input int n);
        wr(ADDR_TIMER_CTRL, 8'h00);
        wr(ADDR_COUNTER, start);
        wr(ADDR_TIMER_CTRL, ctrl);
        idle(n);
        wr(ADDR_TIMER_CTRL, 8'h00);
        rd(ADDR_COUNTER, seen);
    endtask

    task automatic report_and_stop;
        if (errors == 0 && totalChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #(25 * 4000);
        errors++;
        report_and_stop();
    end

    initial begin
        sysClk = 1'b0;
        reset = 1'b1;
        regAddr = 8'h00;
        regWriteData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        fastPeriphClock = 1'b0;
        globalIrqEnable = 1'b1;
        legacyMode = 1'b1;
        portDirection = 1'b0;
        compareAVectorAck = 1'b0;
        overflowVectorAck = 1'b0;
        errors = 0;
        totalChecks = 0;
        repeat (4) @(posedge sysClk);
        reset <= 1'b0;
        foreach (resetAddr[i]) rdchk(resetAddr[i], resetVal[i]);
        wr(ADDR_IRQ_MASK, 8'hFF);
        rdchk(ADDR_IRQ_MASK, 8'h44);
        wr(ADDR_TIMER_CTRL, 8'hF0);
        rdchk(ADDR_TIMER_CTRL, 8'hF0);
        wr(ADDR_TIMER_CTRL, 8'h00);
        wr(ADDR_COMPARE_A, 8'h5A);
        wr(ADDR_COUNTER, 8'h5A);
        rdchk(ADDR_COUNTER, 8'h5A);
        idle(10);
        rdchk(ADDR_COUNTER, 8'h5A);
        rdchk(ADDR_IRQ_FLAGS, 8'h00);
        wr(ADDR_COMPARE_A, 8'h80);
        run(8'hFE, 8'h05, 6);
        rdchk(ADDR_IRQ_FLAGS, 8'h04);
        chk({7'h00, overflowIrq}, 8'h01);
        @(posedge sysClk);
        overflowVectorAck <= 1'b1;
        @(posedge sysClk);
        overflowVectorAck <= 1'b0;
        idle(2);
        chk({7'h00, overflowIrq}, 8'h00);
        rdchk(ADDR_IRQ_FLAGS, 8'h00);
        run(8'h7C, 8'h05, 8);
        rdchk(ADDR_IRQ_FLAGS, 8'h40);
        chk({7'h00, compareAIrq}, 8'h01);
        @(posedge sysClk);
        globalIrqEnable <= 1'b0;
        idle(2);
        chk({7'h00, compareAIrq}, 8'h00);
        globalIrqEnable <= 1'b1;
        wr(ADDR_IRQ_FLAGS, 8'h40);
        idle(2);
        rdchk(ADDR_IRQ_FLAGS, 8'h00);
        chk({7'h00, compareAIrq}, 8'h00);
        run(8'h70, 8'h85, 40);
        chk({7'h00, seen < 8'h40}, 8'h01);
        run(8'h70, 8'h05, 40);
        chk({7'h00, seen > 8'h88}, 8'h01);
        run(8'h00, 8'h01, 60);
        chk({7'h00, seen != 8'h00}, 8'h01);
        wr(ADDR_IRQ_FLAGS, 8'hFF);
        wr(ADDR_GENERAL_CTRL, 8'h02);
        rdchk(ADDR_GENERAL_CTRL, 8'h00);
        portDirection <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_TIMER_CTRL, {2'b00, modeSeq[i], 4'h0});
            wr(ADDR_GENERAL_CTRL, 8'h04);
            idle(2);
            chk({6'h00, compareAOutputEnable, compareAOutput & compareAOutputEnable}, {6'h00, pinSeq[i]});
        end
        rdchk(ADDR_IRQ_FLAGS, 8'h00);
        // Short PWM period: count never passes compare-C, compare-C resets set overflow
        wr(ADDR_COMPARE_C, 8'h0F);
        run(8'h00, 8'h45, 40);
        chk({7'h00, seen <= 8'h0F}, 8'h01);
        rdchk(ADDR_IRQ_FLAGS, 8'h04);
        // Buffered compare value is what software reads back in PWM
        wr(ADDR_TIMER_CTRL, 8'h40);
        wr(ADDR_COMPARE_A, 8'h33);
        rdchk(ADDR_COMPARE_A, 8'h33);
        // Outside legacy mode the enable bit shows what software stored
        @(posedge sysClk);
        legacyMode <= 1'b0;
        rdchk(ADDR_PLL_CTRL, 8'h00);
        wr(ADDR_PLL_CTRL, 8'hFF);
        rdchk(ADDR_PLL_CTRL, 8'h04);
        report_and_stop();
    end
endmodule
`default_nettype wire
